// file: rtl/tccu_pkg.sv
package tccu_pkg;

   // register bus geometry
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;

   // register offsets
   localparam logic [3:0] OFS_CTRL_A = 4'h0;
   localparam logic [3:0] OFS_CTRL_B = 4'h1;
   localparam logic [3:0] OFS_CTRL_D = 4'h2;
   localparam logic [3:0] OFS_FORCE = 4'h3;
   localparam logic [3:0] OFS_FLAGS = 4'h4;
   localparam logic [3:0] OFS_IRQ_EN = 4'h5;
   localparam logic [3:0] OFS_CAP_L = 4'h6;
   localparam logic [3:0] OFS_CAP_H = 4'h7;
   localparam logic [3:0] OFS_CMPA_L = 4'h8;
   localparam logic [3:0] OFS_CMPA_H = 4'h9;
   localparam logic [3:0] OFS_CMPB_L = 4'hA;
   localparam logic [3:0] OFS_CMPB_H = 4'hB;

   // field positions
   localparam int unsigned CTRLA_ACT_A_LSB = 6;
   localparam int unsigned CTRLA_ACT_B_LSB = 4;
   localparam int unsigned CTRLA_WGM_LSB = 0;
   localparam int unsigned CTRLB_FILT_EN = 7;
   localparam int unsigned CTRLB_EDGE_RISE = 6;
   localparam int unsigned CTRLB_CMP_SEL = 5;
   localparam int unsigned FLAG_CAP = 0;
   localparam int unsigned FLAG_CMPA = 1;
   localparam int unsigned FLAG_CMPB = 2;

   // reset values
   localparam logic [7:0] RST_CTRL_A = 8'h00;
   localparam logic [7:0] RST_CTRL_B = 8'h00;
   localparam logic [1:0] RST_CTRL_D = 2'h0;
   localparam logic [2:0] RST_IRQ_EN = 3'h0;
   localparam logic [15:0] RST_CMP = 16'h0000;

   // samples that must agree before the filter output moves
   localparam int unsigned FILTER_SAMPLES = 4;

   // output actions at a match
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;

   // waveform modes with special meaning here
   localparam logic [3:0] WGM_NORMAL = 4'h0;
   localparam logic [3:0] WGM_CTC_CMPA = 4'h4;
   localparam logic [3:0] WGM_PFC_CAP = 4'h8;
   localparam logic [3:0] WGM_PFC_CMPA = 4'h9;
   localparam logic [3:0] WGM_PC_CAP = 4'hA;
   localparam logic [3:0] WGM_CTC_CAP = 4'hC;
   localparam logic [3:0] WGM_FAST_CAP = 4'hE;

   typedef struct packed {
      logic drive;
      logic level;
   } tccu_pin_t;

   function automatic logic is_pwm(input logic [3:0] wgm);
      return !(wgm == WGM_NORMAL || wgm == WGM_CTC_CMPA || wgm == WGM_CTC_CAP);
   endfunction

   function automatic logic cap_is_top(input logic [3:0] wgm);
      return wgm == WGM_PFC_CAP || wgm == WGM_PC_CAP || wgm == WGM_CTC_CAP ||
         wgm == WGM_FAST_CAP;
   endfunction

   function automatic logic load_at_bottom(input logic [3:0] wgm);
      return wgm == WGM_PFC_CAP || wgm == WGM_PFC_CMPA;
   endfunction

   function automatic logic apply_action(input logic [1:0] act, input logic cur);
      logic res;
      res = cur;
      case (act)
         ACT_TOGGLE: res = ~cur;
         ACT_CLEAR: res = 1'b0;
         ACT_SET: res = 1'b1;
         default: res = cur;
      endcase
      return res;
   endfunction

endpackage

// file: rtl/tccu_capture_compare.sv
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
// What this block does
// - comparator select bit picks capture trigger source
// - source change may capture; software clears flag
// - filter adds four clocks of capture delay
// - filter and edge inputs off in capture-top modes
// - filter output moves after four equal samples
// - filter enabled by bit, samples system clock
// - every capture overwrites the capture register
// - equality sets compare flag on next tick
// - enabled flags request interrupt; ack or write-one clears
// - compare A value offered as counter top
// - PWM modes double buffer; others write directly
// - CPU reaches buffer or active compare register
// - compare high byte read bypasses temp register
// - high byte to temp, low write moves both
// - force strobe acts like match on output, no flag; non-PWM only
// - counter write blocks matches on next tick
// - counter written equal top loses top match
// - output state kept across mode changes
// - output action bits act immediately, unbuffered
// - action bits and pin enable pick pin source
// - reset clears the output states to zero
// - edge copies counter and sets flag together
module tccu_capture_compare #(
   parameter int unsigned FILTER_LEN = tccu_pkg::FILTER_SAMPLES
) (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic timer_tick_i,
   input wire logic [15:0] counter_value_i,
   input wire logic counter_write_i,
   input wire logic counter_at_top_i,
   input wire logic counter_at_bottom_i,
   input wire logic capture_input_pin_i,
   input wire logic comparator_output_i,
   input wire logic [1:0] port_data_i,
   input wire logic [2:0] irq_ack_i,
   output logic [2:0] irq_o,
   output logic [15:0] compare_a_top_o,
   output logic [15:0] capture_register_o,
   output logic [3:0] waveform_mode_o,
   output logic [1:0] compare_output_state_o,
   output tccu_pkg::tccu_pin_t [1:0] compare_output_pin_o
);

   // control registers
   logic [7:0] ctrl_a;
   logic [7:0] ctrl_b;
   logic [1:0] timer_control_d;
   logic [2:0] irq_en;
   logic [2:0] flags;
   logic [7:0] temp_hi;
   logic [15:0] capture_register;
   logic [1:0][15:0] cmp_active;
   logic [1:0][15:0] cmp_buffer;
   logic [1:0] out_state;
   logic match_block;
   logic [7:0] rdata;
   logic [2:0] irq_q;
   tccu_pkg::tccu_pin_t [1:0] pin_q;

   // capture path state
   logic [1:0] src_meta;
   logic [1:0] src_sync;
   logic [FILTER_LEN-2:0] filt_hist;
   logic filt_out;
   logic edge_prev;

   // decode
   wire [3:0] waveform_mode_select = ctrl_a[tccu_pkg::CTRLA_WGM_LSB +: 4];
   wire [1:0][1:0] output_action_bits = {ctrl_a[tccu_pkg::CTRLA_ACT_B_LSB +: 2],
      ctrl_a[tccu_pkg::CTRLA_ACT_A_LSB +: 2]};
   wire capture_filter_enable = ctrl_b[tccu_pkg::CTRLB_FILT_EN];
   wire edge_rising = ctrl_b[tccu_pkg::CTRLB_EDGE_RISE];
   wire comparator_capture_select = ctrl_b[tccu_pkg::CTRLB_CMP_SEL];
   wire pwm_mode = tccu_pkg::is_pwm(waveform_mode_select);
   wire cap_top_mode = tccu_pkg::cap_is_top(waveform_mode_select);
   wire buf_load = timer_tick_i & pwm_mode &
      (tccu_pkg::load_at_bottom(waveform_mode_select) ? counter_at_bottom_i :
      counter_at_top_i);

   wire wr_ctrl_a = reg_wr_i && reg_addr_i == tccu_pkg::OFS_CTRL_A;
   wire wr_ctrl_b = reg_wr_i && reg_addr_i == tccu_pkg::OFS_CTRL_B;
   wire wr_ctrl_d = reg_wr_i && reg_addr_i == tccu_pkg::OFS_CTRL_D;
   wire wr_force = reg_wr_i && reg_addr_i == tccu_pkg::OFS_FORCE;
   wire wr_flags = reg_wr_i && reg_addr_i == tccu_pkg::OFS_FLAGS;
   wire wr_irq_en = reg_wr_i && reg_addr_i == tccu_pkg::OFS_IRQ_EN;
   wire wr_cap_l = reg_wr_i && reg_addr_i == tccu_pkg::OFS_CAP_L;
   wire wr_cap_h = reg_wr_i && reg_addr_i == tccu_pkg::OFS_CAP_H;
   wire wr_any_hi = wr_cap_h || (reg_wr_i &&
      (reg_addr_i == tccu_pkg::OFS_CMPA_H || reg_addr_i == tccu_pkg::OFS_CMPB_H));
   wire rd_cap_l = reg_rd_i && reg_addr_i == tccu_pkg::OFS_CAP_L;
   wire [1:0] wr_cmp_l = {reg_wr_i && reg_addr_i == tccu_pkg::OFS_CMPB_L,
      reg_wr_i && reg_addr_i == tccu_pkg::OFS_CMPA_L};
   wire [15:0] cpu_word = {temp_hi, reg_wdata_i};

   // capture input: synchronise both sources before any logic looks
   wire src_sel = comparator_capture_select ? src_sync[1] : src_sync[0];
   wire filt_agree_hi = src_sel & (&filt_hist);
   wire filt_agree_lo = ~src_sel & ~(|filt_hist);
   wire next_filt_out = filt_agree_hi ? 1'b1 : (filt_agree_lo ? 1'b0 : filt_out);
   wire det_in = capture_filter_enable ? filt_out : src_sel;
   wire det_enable = ~cap_top_mode;
   wire rise = det_in & ~edge_prev;
   wire fall = ~det_in & edge_prev;
   // a source switch is just another level change to the detector
   wire capture_hit = det_enable & (edge_rising ? rise : fall);

   // compare channels
   logic [1:0] match_hit;
   logic [1:0] force_hit;
   logic [1:0] next_out_state;
   logic [1:0][15:0] cmp_visible;
   tccu_pkg::tccu_pin_t [1:0] next_pin;

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_chan
         // evaluated on the tick; a counter write just before blocks it
         assign match_hit[ch] = timer_tick_i & ~match_block &
            (counter_value_i == cmp_active[ch]);
         assign force_hit[ch] = wr_force & reg_wdata_i[ch] & ~pwm_mode;
         assign next_out_state[ch] = (match_hit[ch] | force_hit[ch]) ?
            tccu_pkg::apply_action(output_action_bits[ch], out_state[ch]) :
            out_state[ch];
         assign cmp_visible[ch] = pwm_mode ? cmp_buffer[ch] : cmp_active[ch];
         assign next_pin[ch].drive = timer_control_d[ch] &
            (output_action_bits[ch] != tccu_pkg::ACT_NONE);
         assign next_pin[ch].level = next_pin[ch].drive ? next_out_state[ch] :
            port_data_i[ch];

         always_ff @(posedge core_clk_i) begin
            if (srst_i) begin
               cmp_active[ch] <= tccu_pkg::RST_CMP;
               cmp_buffer[ch] <= tccu_pkg::RST_CMP;
               out_state[ch] <= 1'b0;
            end else begin
               out_state[ch] <= next_out_state[ch];
               if (wr_cmp_l[ch]) begin
                  cmp_buffer[ch] <= cpu_word;
               end
               if (wr_cmp_l[ch] && !pwm_mode) begin
                  cmp_active[ch] <= cpu_word;
               end else if (buf_load) begin
                  cmp_active[ch] <= cmp_buffer[ch];
               end
            end
         end
      end
   endgenerate

   // flag handling: a set in the same cycle as a clear wins
   wire [2:0] flag_set = {match_hit[1], match_hit[0], capture_hit};
   wire [2:0] flag_clr = (wr_flags ? reg_wdata_i[2:0] : 3'h0) | irq_ack_i;
   wire [2:0] next_flags = (flags & ~flag_clr) | flag_set;

   // read mux
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      unique case (reg_addr_i)
         tccu_pkg::OFS_CTRL_A: rd_mux = ctrl_a;
         tccu_pkg::OFS_CTRL_B: rd_mux = ctrl_b;
         tccu_pkg::OFS_CTRL_D: rd_mux = {6'h00, timer_control_d};
         tccu_pkg::OFS_FLAGS: rd_mux = {5'h00, flags};
         tccu_pkg::OFS_IRQ_EN: rd_mux = {5'h00, irq_en};
         tccu_pkg::OFS_CAP_L: rd_mux = capture_register[7:0];
         tccu_pkg::OFS_CAP_H: rd_mux = temp_hi;
         tccu_pkg::OFS_CMPA_L: rd_mux = cmp_visible[0][7:0];
         tccu_pkg::OFS_CMPA_H: rd_mux = cmp_visible[0][15:8];
         tccu_pkg::OFS_CMPB_L: rd_mux = cmp_visible[1][7:0];
         tccu_pkg::OFS_CMPB_H: rd_mux = cmp_visible[1][15:8];
         default: rd_mux = 8'h00;
      endcase
   end

   // synchroniser and filter
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         src_meta <= 2'h0;
         src_sync <= 2'h0;
      end else begin
         src_meta <= {comparator_output_i, capture_input_pin_i};
         src_sync <= src_meta;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         filt_hist <= '0;
         filt_out <= 1'b0;
         edge_prev <= 1'b0;
      end else if (det_enable) begin
         filt_hist <= {filt_hist[FILTER_LEN-3:0], src_sel};
         filt_out <= next_filt_out;
         edge_prev <= det_in;
      end
   end

   // capture register, also writable when it defines the top
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         capture_register <= 16'h0000;
      end else if (capture_hit) begin
         capture_register <= counter_value_i;
      end else if (wr_cap_l && cap_top_mode) begin
         capture_register <= cpu_word;
      end
   end

   // shared high byte and control
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         temp_hi <= 8'h00;
      end else if (wr_any_hi) begin
         temp_hi <= reg_wdata_i;
      end else if (rd_cap_l) begin
         temp_hi <= capture_register[15:8];
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         ctrl_a <= tccu_pkg::RST_CTRL_A;
         ctrl_b <= tccu_pkg::RST_CTRL_B;
         timer_control_d <= tccu_pkg::RST_CTRL_D;
         irq_en <= tccu_pkg::RST_IRQ_EN;
      end else begin
         if (wr_ctrl_a) begin
            ctrl_a <= reg_wdata_i;
         end
         if (wr_ctrl_b) begin
            ctrl_b <= reg_wdata_i;
         end
         if (wr_ctrl_d) begin
            timer_control_d <= reg_wdata_i[1:0];
         end
         if (wr_irq_en) begin
            irq_en <= reg_wdata_i[2:0];
         end
      end
   end

   // counter write blocks matches on the next tick, even when stopped
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         match_block <= 1'b0;
      end else if (counter_write_i) begin
         match_block <= 1'b1;
      end else if (timer_tick_i) begin
         match_block <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         flags <= 3'h0;
         irq_q <= 3'h0;
         rdata <= 8'h00;
         pin_q <= '0;
      end else begin
         flags <= next_flags;
         irq_q <= next_flags & irq_en;
         rdata <= reg_rd_i ? rd_mux : 8'h00;
         pin_q <= next_pin;
      end
   end

   assign reg_rdata_o = rdata;
   assign irq_o = irq_q;
   assign compare_a_top_o = cmp_active[0];
   assign capture_register_o = capture_register;
   assign waveform_mode_o = waveform_mode_select;
   assign compare_output_state_o = out_state;
   assign compare_output_pin_o = pin_q;

endmodule

// file: verification/tccu_event_src.sv
`timescale 1ns/1ps
// pin levels launch just after the edge and hold until the bench moves them
module tccu_event_src (
   input wire logic core_clk_i,
   input wire logic pin_lvl_i,
   input wire logic cmp_lvl_i,
   output logic capture_input_pin_o = 1'b0,
   output logic comparator_output_o = 1'b0,
   output logic [1:0] port_data_o = 2'h0
);
   always_ff @(posedge core_clk_i) begin
      capture_input_pin_o <= pin_lvl_i;
      comparator_output_o <= cmp_lvl_i;
      // port keeps moving so a stale pin level cannot pass
      port_data_o <= port_data_o + 2'h1;
   end
endmodule

// file: verification/tccu_capture_compare_assertions.sv
`timescale 1ns/1ps
module tccu_cc_checker #(
   parameter int unsigned FILTER_LEN = tccu_pkg::FILTER_SAMPLES
) (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic timer_tick_i,
   input wire logic [15:0] counter_value_i,
   input wire logic counter_write_i,
   input wire logic capture_input_pin_i,
   input wire logic [1:0] port_data_i,
   input wire logic [2:0] irq_o,
   input wire logic [15:0] compare_a_top_o,
   input wire logic [15:0] capture_register_o,
   input wire logic [3:0] waveform_mode_o,
   input wire logic [1:0] compare_output_state_o,
   input wire tccu_pkg::tccu_pin_t [1:0] compare_output_pin_o
);
   logic [1:0] act_a;
   logic en_a, filt, rise, sel, pe_a, blk;
   logic npwm, match, cap_ok;
   assign npwm = waveform_mode_o == tccu_pkg::WGM_NORMAL ||
      waveform_mode_o == tccu_pkg::WGM_CTC_CMPA || waveform_mode_o == tccu_pkg::WGM_CTC_CAP;
   assign match = timer_tick_i && counter_value_i == compare_a_top_o && !blk && !counter_write_i;
   // capture-top modes freeze the detector
   assign cap_ok = rise && !sel && !(waveform_mode_o[3] && !waveform_mode_o[0]);
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         act_a <= 2'h0;
         {en_a, filt, rise, sel, pe_a, blk} <= 6'h00;
      end else begin
         if (reg_wr_i && reg_addr_i == tccu_pkg::OFS_CTRL_A) begin
            act_a <= reg_wdata_i[7:6];
         end
         if (reg_wr_i && reg_addr_i == tccu_pkg::OFS_CTRL_B) begin
            {filt, rise, sel} <= reg_wdata_i[7:5];
         end
         if (reg_wr_i && reg_addr_i == tccu_pkg::OFS_IRQ_EN) begin
            en_a <= reg_wdata_i[1];
         end
         if (reg_wr_i && reg_addr_i == tccu_pkg::OFS_CTRL_D) begin
            pe_a <= reg_wdata_i[0];
         end
         blk <= counter_write_i || (blk && !timer_tick_i);
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   reset_state_a: assert property ($past(srst_i) |-> compare_output_state_o == 2'h0)
      else $error("output state not cleared");
   match_irq_a: assert property (match && en_a |-> ##2 irq_o[1])
      else $error("match gave no request");
   match_out_a: assert property (match && act_a == tccu_pkg::ACT_TOGGLE |=>
      compare_output_state_o[0] != $past(compare_output_state_o[0]))
      else $error("match did not toggle");
   raw_cap_a: assert property (!filt && cap_ok && $rose(capture_input_pin_i) ##1
      capture_input_pin_i[*2] |=> capture_register_o == $past(counter_value_i))
      else $error("raw capture wrong");
   filt_cap_a: assert property (FILTER_LEN == 4 && filt && cap_ok &&
      $rose(capture_input_pin_i) ##1 capture_input_pin_i[*6] |=>
      capture_register_o == $past(counter_value_i))
      else $error("filtered capture wrong");
   // a driven pin carries the state written at the same edge, not the old one
   pin_src_a: assert property (!$past(srst_i) |-> compare_output_pin_o[0] ==
      ($past(pe_a && act_a != 2'h0) ? {1'b1, compare_output_state_o[0]} :
      {1'b0, $past(port_data_i[0])}))
      else $error("pin source wrong");
   cmph_read_a: assert property (reg_rd_i && reg_addr_i == tccu_pkg::OFS_CMPA_H && npwm |=>
      reg_rdata_o == $past(compare_a_top_o[15:8]))
      else $error("compare high read wrong");
   force_set_a: assert property (reg_wr_i && reg_addr_i == tccu_pkg::OFS_FORCE &&
      reg_wdata_i[0] && npwm && act_a == tccu_pkg::ACT_SET && !timer_tick_i |=>
      compare_output_state_o[0])
      else $error("force did not set");
endmodule

bind tccu_capture_compare tccu_cc_checker #(.FILTER_LEN(FILTER_LEN)) tccu_cc_checker_inst (
   .core_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
   .timer_tick_i, .counter_value_i, .counter_write_i, .capture_input_pin_i, .port_data_i,
   .irq_o, .compare_a_top_o, .capture_register_o, .waveform_mode_o, .compare_output_state_o,
   .compare_output_pin_o);

// file: verification/tccu_capture_compare_tb.sv
`timescale 1ns/1ps
module tccu_capture_compare_tb;
   logic core_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [3:0] reg_addr_i = 4'h0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic timer_tick_i = 1'b0;
   logic [15:0] counter_value_i = 16'h0000;
   logic counter_write_i = 1'b0;
   logic counter_at_top_i = 1'b0;
   logic counter_at_bottom_i = 1'b0;
   logic [2:0] irq_ack_i = 3'h0;
   logic pin_lvl = 1'b0;
   logic cmp_lvl = 1'b0;
   logic capture_input_pin_i, comparator_output_i, rd_seen;
   logic [1:0] port_data_i, compare_output_state_o;
   logic [7:0] reg_rdata_o;
   logic [2:0] irq_o;
   logic [15:0] compare_a_top_o, capture_register_o, v, w, c;
   logic [3:0] waveform_mode_o;
   tccu_pkg::tccu_pin_t [1:0] compare_output_pin_o;
   logic [7:0] exp_q[$];
   int miscompares = 0;
   int n_tests = 0;
   int cyc = 0;

   initial begin
      forever #4 core_clk_i = ~core_clk_i;
   end

   tccu_event_src tccu_event_src_inst (.core_clk_i, .pin_lvl_i(pin_lvl), .cmp_lvl_i(cmp_lvl),
      .capture_input_pin_o(capture_input_pin_i), .comparator_output_o(comparator_output_i),
      .port_data_o(port_data_i));

   tccu_capture_compare tccu_capture_compare_inst (.core_clk_i, .srst_i, .reg_addr_i,
      .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .timer_tick_i, .counter_value_i,
      .counter_write_i, .counter_at_top_i, .counter_at_bottom_i, .capture_input_pin_i,
      .comparator_output_i, .port_data_i, .irq_ack_i, .irq_o, .compare_a_top_o,
      .capture_register_o, .waveform_mode_o, .compare_output_state_o, .compare_output_pin_o);

   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_sim();
      if (miscompares == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      exp_q.push_back(e);
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
   endtask

   task automatic tick();
      @(posedge core_clk_i);
      timer_tick_i <= 1'b1;
      @(posedge core_clk_i);
      timer_tick_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
   endtask

   task automatic hold(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask

   always @(posedge core_clk_i) begin
      rd_seen <= reg_rd_i;
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         end_sim();
      end
   end

   // read data stands only in the cycle after the strobe
   always @(negedge core_clk_i) begin
      if (rd_seen === 1'b1) begin
         check("rdata", {8'h00, reg_rdata_o}, {8'h00, exp_q.pop_front()});
      end
   end

   initial begin
      void'($urandom(32'h9e38a8e1));
      hold(10);
      srst_i <= 1'b0;
      rd(tccu_pkg::OFS_CMPA_H, 8'h00);
      rd(4'hF, 8'h00);
      // keep both compare words away from zero, where compare B sits
      v = 16'($urandom) | 16'h0001;
      v[15] = 1'b0;
      w = ~v;
      wr(tccu_pkg::OFS_CMPA_H, v[15:8]);
      wr(tccu_pkg::OFS_CMPA_L, v[7:0]);
      rd(tccu_pkg::OFS_CMPA_L, v[7:0]);
      rd(tccu_pkg::OFS_CMPA_H, v[15:8]);
      check("cmp_a", compare_a_top_o, v);
      wr(tccu_pkg::OFS_CTRL_A, 8'h0F);
      wr(tccu_pkg::OFS_CMPA_H, w[15:8]);
      wr(tccu_pkg::OFS_CMPA_L, w[7:0]);
      tick();
      check("cmp_a", compare_a_top_o, v);
      counter_at_top_i <= 1'b1;
      tick();
      counter_at_top_i <= 1'b0;
      check("cmp_a", compare_a_top_o, w);
      wr(tccu_pkg::OFS_CTRL_A, 8'h09);
      wr(tccu_pkg::OFS_CMPA_H, v[15:8]);
      wr(tccu_pkg::OFS_CMPA_L, v[7:0]);
      counter_at_top_i <= 1'b1;
      tick();
      counter_at_top_i <= 1'b0;
      check("cmp_a", compare_a_top_o, w);
      counter_at_bottom_i <= 1'b1;
      tick();
      counter_at_bottom_i <= 1'b0;
      check("cmp_a", compare_a_top_o, v);
      // compare B still holds zero, so every tick at count zero matched it
      rd(tccu_pkg::OFS_FLAGS, 8'h04);
      wr(tccu_pkg::OFS_FLAGS, 8'h04);
      wr(tccu_pkg::OFS_IRQ_EN, 8'h02);
      wr(tccu_pkg::OFS_CTRL_A, 8'h40);
      counter_value_i <= v;
      tick();
      check("state", {14'h0, compare_output_state_o}, 16'h0001);
      rd(tccu_pkg::OFS_FLAGS, 8'h02);
      check("irq", {13'h0, irq_o}, 16'h0002);
      irq_ack_i <= 3'h2;
      hold(1);
      irq_ack_i <= 3'h0;
      rd(tccu_pkg::OFS_FLAGS, 8'h00);
      counter_write_i <= 1'b1;
      hold(1);
      counter_write_i <= 1'b0;
      tick();
      rd(tccu_pkg::OFS_FLAGS, 8'h00);
      tick();
      rd(tccu_pkg::OFS_FLAGS, 8'h02);
      wr(tccu_pkg::OFS_FLAGS, 8'h02);
      rd(tccu_pkg::OFS_FLAGS, 8'h00);
      wr(tccu_pkg::OFS_CTRL_A, 8'hC0);
      wr(tccu_pkg::OFS_FORCE, 8'h01);
      rd(tccu_pkg::OFS_FLAGS, 8'h00);
      wr(tccu_pkg::OFS_CTRL_D, 8'h01);
      hold(2);
      check("pin", {14'h0, compare_output_pin_o[0]}, 16'h0003);
      wr(tccu_pkg::OFS_CTRL_A, 8'hCF);
      check("state", {14'h0, compare_output_state_o}, 16'h0001);
      wr(tccu_pkg::OFS_CTRL_A, 8'h00);
      wr(tccu_pkg::OFS_CTRL_B, 8'h40);
      c = 16'($urandom);
      counter_value_i <= c;
      pin_lvl <= 1'b1;
      hold(8);
      rd(tccu_pkg::OFS_CAP_L, c[7:0]);
      rd(tccu_pkg::OFS_CAP_H, c[15:8]);
      rd(tccu_pkg::OFS_FLAGS, 8'h01);
      wr(tccu_pkg::OFS_FLAGS, 8'h01);
      wr(tccu_pkg::OFS_CTRL_B, 8'hC0);
      pin_lvl <= 1'b0;
      hold(8);
      counter_value_i <= ~c;
      pin_lvl <= 1'b1;
      hold(2);
      pin_lvl <= 1'b0;
      hold(10);
      check("cap", capture_register_o, c);
      pin_lvl <= 1'b1;
      hold(5);
      check("cap", capture_register_o, c);
      hold(5);
      check("cap", capture_register_o, ~c);
      wr(tccu_pkg::OFS_CTRL_B, 8'h80);
      wr(tccu_pkg::OFS_FLAGS, 8'h01);
      rd(tccu_pkg::OFS_FLAGS, 8'h00);
      wr(tccu_pkg::OFS_CTRL_B, 8'h60);
      wr(tccu_pkg::OFS_FLAGS, 8'h01);
      counter_value_i <= v;
      cmp_lvl <= 1'b1;
      hold(8);
      check("cap", capture_register_o, v);
      rd(tccu_pkg::OFS_FLAGS, 8'h01);
      wr(tccu_pkg::OFS_CTRL_A, 8'h0C);
      wr(tccu_pkg::OFS_CTRL_B, 8'h40);
      pin_lvl <= 1'b0;
      hold(6);
      counter_value_i <= w;
      pin_lvl <= 1'b1;
      hold(10);
      check("cap", capture_register_o, v);
      srst_i <= 1'b1;
      hold(2);
      srst_i <= 1'b0;
      hold(1);
      check("state", {14'h0, compare_output_state_o}, 16'h0000);
      end_sim();
   end
endmodule
